// ---- ps_cfg_port.sv ----
// passive serial configuration port: loader state machine and pin drivers
// assumes an external host driving clock, data and request pins
`timescale 1ns/1ps
`default_nettype none
// Contract
// - in user mode the request, status and completion lines stay high, and a low request starts reconfiguration.
// - after power-up the status line is driven low for the whole power-on-reset delay.
// - the completion line is held low after power-up, before and during configuration.
// - the host sends the whole bitstream and completion is released only after error-free reception.
// - after completion goes high two more falling clock edges start initialization and user mode.
// - when the loaded option enables it, the initialization-done output goes low once that bit is loaded.
// - after configuration the data pin becomes a user pin governed by the loaded dual-purpose setting.
module ps_cfg_port #(
    parameter int unsigned POR_CYCLES = ps_cfg_pkg::POR_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // link from host
    input  wire logic serial_config_clock,
    input  wire logic serial_config_data,
    input  wire logic config_request_n,
    // open-drain status and completion (enable high pulls low)
    output var  logic config_status_n_o,
    output var  logic config_status_n_oe,
    output var  logic config_complete_o,
    output var  logic config_complete_oe,
    // initialization-done pin
    output var  logic init_done_o,
    output var  logic init_done_oe,
    // data pin in user mode
    output var  logic user_data_o,
    output var  logic user_data_oe,
    // user data in, and state
    output var  logic user_data_i,
    output var  logic user_mode
);
    typedef struct packed {
        ps_cfg_pkg::cfg_state_e  state;
        logic [ps_cfg_pkg::POR_CNT_W-1:0] por_cnt;
        logic [ps_cfg_pkg::BIT_CNT_W-1:0] bit_cnt;
        logic [ps_cfg_pkg::STREAM_BITS-1:0] stream;
        logic [7:0]              crc;
        logic [1:0]              init_cnt;
        ps_cfg_pkg::cfg_pins_s   pins;
        logic                    user_in;
    } port_s;

    port_s                    st_r;
    port_s                    st_nxt;
    ps_cfg_pkg::link_sample_s smp;
    logic [7:0]               crc_bit;

    ps_link_sync u_sync (
        .clk                 (clk),
        .rst                 (rst),
        .serial_config_clock (serial_config_clock),
        .serial_config_data  (serial_config_data),
        .config_request_n    (config_request_n),
        .smp                 (smp)
    );

    // running check over the payload, one bit at a time
    always_comb begin
        crc_bit = {st_r.crc[6:0], 1'b0} ^ ({8{st_r.crc[7] ^ smp.data}} & 8'h07);
    end

    always_comb begin
        st_nxt         = st_r;
        st_nxt.user_in = smp.data;
        unique case (st_r.state)
            ps_cfg_pkg::ST_POR: begin
                st_nxt.pins.status_n_oe = 1'b1;
                st_nxt.pins.complete_oe = 1'b1;
                if (32'(st_r.por_cnt) >= POR_CYCLES - 1) begin
                    st_nxt.state = ps_cfg_pkg::ST_CLEAR;
                end else begin
                    st_nxt.por_cnt = st_r.por_cnt + 16'h0001;
                end
            end
            ps_cfg_pkg::ST_CLEAR: begin
                st_nxt.bit_cnt  = 8'h00;
                st_nxt.crc      = ps_cfg_pkg::CRC_SEED;
                st_nxt.init_cnt = 2'h0;
                st_nxt.stream   = '0;
                st_nxt.pins     = '{status_n_oe: 1'b1, complete_oe: 1'b1, init_done_o: 1'b0,
                                    init_done_oe: 1'b0, data_o: 1'b0, data_oe: 1'b0, user_mode: 1'b0};
                if (smp.req_n) begin
                    st_nxt.pins.status_n_oe = 1'b0;
                    st_nxt.state            = ps_cfg_pkg::ST_LOAD;
                end
            end
            ps_cfg_pkg::ST_LOAD: begin
                st_nxt.pins.complete_oe = 1'b1;
                if (smp.rise) begin
                    st_nxt.stream  = {smp.data, st_r.stream[ps_cfg_pkg::STREAM_BITS-1:1]};
                    st_nxt.bit_cnt = st_r.bit_cnt + 8'h01;
                    if (st_r.bit_cnt < 8'(ps_cfg_pkg::CRC_LO)) begin
                        st_nxt.crc = crc_bit;
                    end
                    if (st_r.bit_cnt == 8'(ps_cfg_pkg::OPT_INIT_DONE_EN) && smp.data) begin
                        st_nxt.pins.init_done_oe = 1'b1;
                        st_nxt.pins.init_done_o  = 1'b0;
                    end
                    if (st_r.bit_cnt == ps_cfg_pkg::STREAM_LAST) begin
                        if ({smp.data, st_r.stream[ps_cfg_pkg::STREAM_BITS-1:ps_cfg_pkg::CRC_LO+1]} == st_r.crc) begin
                            st_nxt.pins.complete_oe = 1'b0;
                            st_nxt.state            = ps_cfg_pkg::ST_INIT;
                        end else begin
                            st_nxt.pins.status_n_oe = 1'b1;
                            st_nxt.state            = ps_cfg_pkg::ST_ERROR;
                        end
                    end
                end
            end
            ps_cfg_pkg::ST_INIT: begin
                if (smp.fall) begin
                    st_nxt.init_cnt = st_r.init_cnt + 2'h1;
                    if (st_r.init_cnt == ps_cfg_pkg::INIT_LAST) begin
                        st_nxt.state          = ps_cfg_pkg::ST_USER;
                        st_nxt.pins.user_mode = 1'b1;
                        st_nxt.pins.init_done_o = 1'b1;
                        st_nxt.pins.data_oe = st_r.stream[ps_cfg_pkg::OPT_DATA_USER_EN] &
                                              st_r.stream[ps_cfg_pkg::OPT_DATA_USER_OE];
                    end
                end
            end
            ps_cfg_pkg::ST_USER: begin
                st_nxt.pins.data_o = 1'b0;
                st_nxt.pins.status_n_oe = 1'b0;
                st_nxt.pins.complete_oe = 1'b0;
            end
            ps_cfg_pkg::ST_ERROR: begin
                st_nxt.pins.status_n_oe = 1'b1;
                st_nxt.pins.complete_oe = 1'b1;
            end
            default: begin
                st_nxt.state = ps_cfg_pkg::ST_CLEAR;
            end
        endcase
        // a low request restarts from any state after power-up
        if (!smp.req_n && st_r.state != ps_cfg_pkg::ST_POR) begin
            st_nxt.state = ps_cfg_pkg::ST_CLEAR;
            st_nxt.pins  = '{status_n_oe: 1'b1, complete_oe: 1'b1, init_done_o: 1'b0,
                             init_done_oe: 1'b0, data_o: 1'b0, data_oe: 1'b0, user_mode: 1'b0};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{state: ps_cfg_pkg::ST_POR, por_cnt: 16'h0000, bit_cnt: 8'h00,
                      stream: '0, crc: 8'h00, init_cnt: 2'h0,
                      pins: '{status_n_oe: 1'b1, complete_oe: 1'b1, init_done_o: 1'b0,
                              init_done_oe: 1'b0, data_o: 1'b0, data_oe: 1'b0, user_mode: 1'b0},
                      user_in: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign config_status_n_o  = 1'b0;
    assign config_complete_o  = 1'b0;
    assign config_status_n_oe = st_r.pins.status_n_oe;
    assign config_complete_oe = st_r.pins.complete_oe;
    assign init_done_o        = st_r.pins.init_done_o;
    assign init_done_oe       = st_r.pins.init_done_oe;
    assign user_data_o        = st_r.pins.data_o;
    assign user_data_oe       = st_r.pins.data_oe;
    assign user_data_i        = st_r.user_in;
    assign user_mode          = st_r.pins.user_mode;
endmodule : ps_cfg_port
`default_nettype wire

// ---- ps_cfg_pkg.sv ----
// package for the passive serial configuration port
// assumes a 200 MHz core clock; no registers reachable by software
package ps_cfg_pkg;

    // power-on-reset delay, in microseconds, and cycles derived from it
    localparam int unsigned POR_DELAY_US     = 100;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned POR_CYCLES       = POR_DELAY_US * CLK_MHZ;
    localparam int unsigned POR_CNT_W        = 16;

    // bitstream layout
    localparam int unsigned STREAM_BITS      = 64;
    localparam int unsigned BIT_CNT_W        = 8;
    localparam logic [7:0]  STREAM_LAST      = 8'h3f;
    localparam int unsigned OPT_INIT_DONE_EN = 8;
    localparam int unsigned OPT_DATA_USER_EN = 9;
    localparam int unsigned OPT_DATA_USER_OE = 10;
    localparam int unsigned CRC_LO           = 56;
    localparam logic [7:0]  CRC_SEED         = 8'h00;
    localparam int unsigned INIT_EDGES       = 2;
    localparam logic [1:0]  INIT_LAST        = 2'h1;

    typedef enum logic [2:0] {
        ST_POR    = 3'b000,
        ST_CLEAR  = 3'b001,
        ST_LOAD   = 3'b011,
        ST_INIT   = 3'b010,
        ST_USER   = 3'b110,
        ST_ERROR  = 3'b111
    } cfg_state_e;

    typedef struct packed {
        logic status_n_oe;
        logic complete_oe;
        logic init_done_o;
        logic init_done_oe;
        logic data_o;
        logic data_oe;
        logic user_mode;
    } cfg_pins_s;

    typedef struct packed {
        logic rise;
        logic fall;
        logic data;
        logic req_n;
    } link_sample_s;

endpackage : ps_cfg_pkg

// ---- ps_link_sync.sv ----
// synchroniser and edge finder for the link pins
// assumes clock, data and request pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module ps_link_sync (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // pins
    input  wire logic                     serial_config_clock,
    input  wire logic                     serial_config_data,
    input  wire logic                     config_request_n,
    // sampled view
    output var  ps_cfg_pkg::link_sample_s smp
);
    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] dat_s;
        logic [1:0] req_s;
        logic       clk_d;
        ps_cfg_pkg::link_sample_s smp;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.clk_s    = {st_r.clk_s[0], serial_config_clock};
        st_nxt.dat_s    = {st_r.dat_s[0], serial_config_data};
        st_nxt.req_s    = {st_r.req_s[0], config_request_n};
        st_nxt.clk_d    = st_r.clk_s[1];
        st_nxt.smp.rise = st_r.clk_s[1] & ~st_r.clk_d;
        st_nxt.smp.fall = ~st_r.clk_s[1] & st_r.clk_d;
        st_nxt.smp.data = st_r.dat_s[1];
        st_nxt.smp.req_n = st_r.req_s[1];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{clk_s: 2'h0, dat_s: 2'h0, req_s: 2'h3, clk_d: 1'b0,
                      smp: '{rise: 1'b0, fall: 1'b0, data: 1'b0, req_n: 1'b1}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign smp = st_r.smp;
endmodule : ps_link_sync
`default_nettype wire

// ---- ps_cfg_port_checker.sv ----
// checker: pin relations of the configuration port
// assumes bind onto ps_cfg_port; an enable high pulls its line low
`timescale 1ns/1ps
`default_nettype none
module ps_cfg_port_checker #(
    parameter int unsigned POR_CYCLES = 50
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic config_request_n,
    input wire logic config_status_n_oe,
    input wire logic config_complete_oe,
    input wire logic init_done_o,
    input wire logic init_done_oe,
    input wire logic user_data_oe,
    input wire logic user_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    int unsigned por_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) por_cnt <= 0;
        else if (por_cnt < POR_CYCLES) por_cnt <= por_cnt + 1;
    end
    a_por_hold: assert property (por_cnt < POR_CYCLES |-> config_status_n_oe && config_complete_oe)
        else $error("lines released during power-on delay");
    a_user_high: assert property (user_mode && $past(user_mode) |-> !config_status_n_oe && !config_complete_oe)
        else $error("line low in user mode");
    a_req_restart: assert property (user_mode && !config_request_n |-> ##[0:8] (config_status_n_oe && !user_mode))
        else $error("request did not restart");
    a_done_clean: assert property ($fell(config_complete_oe) |-> !config_status_n_oe && !user_mode)
        else $error("completion released with error");
    a_user_late: assert property ($rose(user_mode) |-> !$past(config_complete_oe, 12))
        else $error("user mode too soon after completion");
    a_init_load: assert property ($rose(init_done_oe) |-> !user_mode && config_complete_oe && !init_done_o)
        else $error("init-done not low during load");
    a_init_user: assert property (user_mode && init_done_oe |-> init_done_o)
        else $error("init-done low in user mode");
    a_data_user: assert property (user_data_oe |-> user_mode)
        else $error("data pin driven outside user mode");
endmodule : ps_cfg_port_checker
bind ps_cfg_port ps_cfg_port_checker #(.POR_CYCLES(POR_CYCLES)) chk (.clk(clk), .rst(rst),
    .config_request_n(config_request_n), .config_status_n_oe(config_status_n_oe),
    .config_complete_oe(config_complete_oe), .init_done_o(init_done_o), .init_done_oe(init_done_oe),
    .user_data_oe(user_data_oe), .user_mode(user_mode));
`default_nettype wire

// ---- ps_host.sv ----
// host model: shifts the bitstream on the serial clock and data pins
// assumes an 80 ns link clock, unrelated in phase to the core clock
`timescale 1ns/1ps
`default_nettype none
module ps_host (
    // link pins
    output var logic serial_config_clock,
    output var logic serial_config_data,
    output var logic config_request_n
);
    initial begin
        serial_config_clock = 1'b0;
        serial_config_data  = 1'b1;
        config_request_n    = 1'b1;
    end
    task automatic send(input logic [63:0] s);
        int i;
        #3.7;
        for (i = 0; i < 64; i++) begin
            serial_config_data = s[i];
            #20 serial_config_clock = 1'b1;
            #40 serial_config_clock = 1'b0;
            #20;
        end
        serial_config_data = ~s[63];
    endtask : send
    task automatic fall2();
        repeat (2) begin
            #40 serial_config_clock = 1'b1;
            #40 serial_config_clock = 1'b0;
        end
    endtask : fall2
    task automatic req(input logic v);
        config_request_n = v;
    endtask : req
endmodule : ps_host
`default_nettype wire

// ---- tb.sv ----
// testbench for the passive serial configuration port
// assumes host model ps_host and the checker bound onto ps_cfg_port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    localparam int unsigned POR = 50;
    logic clk       = 1'b0;
    logic rst       = 1'b1;
    int   bad_count = 0;
    int   n_tests   = 0;
    wire  scc, scd, req_n, st_o, st_oe, cd_o, cd_oe, id_o, id_oe, ud_o, ud_oe, ud_i, um;
    wire  st_line   = st_oe ? st_o : 1'b1;
    always #2.5 clk = ~clk;
    ps_cfg_port #(.POR_CYCLES(POR)) uut (.clk(clk), .rst(rst), .serial_config_clock(scc),
        .serial_config_data(scd), .config_request_n(req_n), .config_status_n_o(st_o),
        .config_status_n_oe(st_oe), .config_complete_o(cd_o), .config_complete_oe(cd_oe),
        .init_done_o(id_o), .init_done_oe(id_oe), .user_data_o(ud_o), .user_data_oe(ud_oe),
        .user_data_i(ud_i), .user_mode(um));
    ps_host host (.serial_config_clock(scc), .serial_config_data(scd), .config_request_n(req_n));
    task automatic close_out();
        $display("tests %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic wait_hi();
        int i;
        for (i = 0; i < 400 && !st_line; i++) @(negedge clk);
        if (!st_line) begin
            bad_count++;
            close_out();
        end
    endtask : wait_hi
    // stream with option bits and trailing crc-8, optionally spoilt
    function automatic logic [63:0] mk(input logic [2:0] o, input logic bad);
        logic [63:0] s;
        logic [7:0]  c;
        int          i;
        s = 64'h00a5_3c96_0f1e_d200;
        s[10:8] = o;
        c = 8'h00;
        for (i = 0; i < 56; i++) c = {c[6:0], 1'b0} ^ ((s[i] ^ c[7]) ? 8'h07 : 8'h00);
        s[63:56] = c ^ {7'h00, bad};
        return s;
    endfunction : mk
    task automatic t_por();
        int n;
        n = 0;
        `CHK("por_done", 1'b1, cd_oe)
        while (st_oe && n < 400) begin
            @(negedge clk);
            n++;
        end
        `CHK("por_len", 1'b1, (n >= POR - 2 && n <= POR + 8))
        `CHK("pre_done", 1'b1, cd_oe)
        `CHK("st_val", 1'b0, st_o)
        `CHK("done_val", 1'b0, cd_o)
    endtask : t_por
    task automatic t_load(input logic [2:0] o, input logic bad);
        wait_hi();
        host.send(mk(o, bad));
        repeat (10) @(negedge clk);
        `CHK("done_oe", bad, cd_oe)
        `CHK("err_oe", bad, st_oe)
        `CHK("init_oe", o[0], id_oe)
        `CHK("init_low", 1'b0, id_o)
        if (!bad) begin
            host.fall2();
            repeat (10) @(negedge clk);
            `CHK("user", 1'b1, um)
            `CHK("user_st", 1'b0, st_oe | cd_oe)
            `CHK("data_oe", o[1] & o[2], ud_oe)
            `CHK("init_user", o[0], id_o & id_oe)
            `CHK("data_out", 1'b0, ud_o)
            `CHK("data_in", scd, ud_i)
        end
    endtask : t_load
    task automatic t_req();
        host.req(1'b0);
        repeat (10) @(negedge clk);
        `CHK("req_st", 1'b1, st_oe)
        `CHK("req_done", 1'b1, cd_oe)
        `CHK("req_user", 1'b0, um)
        host.req(1'b1);
        wait_hi();
        `CHK("req_rel", 1'b1, cd_oe)
    endtask : t_req
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_por();
        t_load(3'b111, 1'b0);
        t_req();
        t_load(3'b000, 1'b1);
        t_req();
        t_load(3'b011, 1'b0);
        close_out();
    end
endmodule : tb
`default_nettype wire
